// ### src/clock_source_switch.sv
// Clock source switch, start-up hold and fail-safe clock monitor.
//
// The address map and register access over Avalon-MM were decided locally.
`timescale 1ns/100ps

// Overview of operation
// [R1] Secondary oscillator runs whenever its enable set.
// [R2] Secondary clocks system only when selected and enabled.
// [R3] PLL gain four, eight or sixteen.
// [R4] Lock status mirrors PLL lock.
// [R5] Group 01 runs the fast RC oscillator.
// [R6] Signed four-bit fine tune of fast RC.
// [R7] Low-power RC clocks timer, watchdog, monitor.
// [R8] Low-power RC on at reset, then keep-alive.
// [R9] Low-power RC off without keep-alive after timer.
// [R10] Monitor enabled keeps low-power RC on except Sleep.
// [R11] Clock failure raises trap, selects fast RC.
// [R12] Failure loads group, sets flag, clears enable.
// [R13] Unstarted source at timer expiry is failure.
// [R14] Watchdog clock unaffected by clock failure.
// [R15] Only four groups; primary mode from configuration.
// [R16] Current group read-only; new group requests switch.
// [R17] Both group fields load from start configuration.
// [R18] Enable rises on switch start; clearing aborts.
// [R19] Monitor select 1x disables switching and monitor.
// [R20] Switching disabled: configuration selects, group reflects.
// [R21] Software avoids sources below 100 kHz.
// [R22] Crystal held for 1024 cycles on restart; the code counts 1024 source edges, 512 cycles.
// [R23] Unlock key pairs precede control register writes.
// [R24] Monitor checks source edges within tick window.
module clock_source_switch #(
  parameter int FAIL_WINDOW_TICKS = clk_sw_pkg::FAIL_WINDOW_DEFAULT
) (
  // Clock and reset
  input wire logic REF_CLK_I,
  input wire logic RESETN_I,
  // Avalon-MM slave
  input wire logic [3:0] AVS_ADDRESS_I,
  input wire logic AVS_READ_I,
  input wire logic AVS_WRITE_I,
  input wire logic [3:0] AVS_BYTEENABLE_I,
  input wire logic [31:0] AVS_WRITEDATA_I,
  output logic [31:0] AVS_READDATA_O,
  output logic AVS_WAITREQUEST_O,
  // Configuration straps, captured at reset
  input wire logic [1:0] START_GROUP_CFG_I,
  input wire logic [3:0] PRIMARY_MODE_CFG_I,
  input wire logic [1:0] MONITOR_SELECT_CFG_I,
  input wire logic WATCHDOG_CFG_ENABLE_I,
  // System status, same clock domain
  input wire logic SLEEP_I,
  input wire logic WATCHDOG_SOFT_ENABLE_I,
  // Asynchronous inputs
  input wire logic POWERUP_TIMER_DONE_I,
  input wire logic PLL_LOCK_I,
  input wire logic LOW_POWER_RC_CLK_I,
  input wire logic OSC_PROBE_I,
  // Oscillator controls
  output logic [1:0] CLK_SELECT_O,
  output logic [3:0] PRIMARY_MODE_O,
  output logic [1:0] PLL_GAIN_O,
  output logic PRIMARY_OSC_EN_O,
  output logic SECONDARY_OSC_EN_O,
  output logic LOW_POWER_RC_EN_O,
  output logic [3:0] FINE_TUNE_O,
  output logic [1:0] OSC_PROBE_SEL_O,
  output logic CLOCK_HOLD_O,
  output logic CLOCK_FAIL_TRAP_O
);
  import clk_sw_pkg::*;

  localparam int MON_W = $clog2(FAIL_WINDOW_TICKS + 1);
  localparam logic [MON_W-1:0] MON_LIMIT = MON_W'(FAIL_WINDOW_TICKS);

  typedef struct packed {
    logic [1:0] cfg_start;
    logic [3:0] cfg_mode;
    logic [1:0] cfg_mon;
    logic cfg_wdt;
    logic [1:0] cur_grp;
    logic [1:0] new_grp;
    logic sosc;
    logic switch_enable;
    logic cf;
    logic [3:0] tune;
    switch_state_e st;
    logic [10:0] sup_cnt;
    logic [MON_W-1:0] mon_cnt;
    logic [1:0] powerup_timer_s;
    logic [1:0] lock_s;
    logic [2:0] low_power_rc_s;
    logic [2:0] probe_s;
    logic powerup_timer_seen;
    key_state_e key_st;
    logic lo_arm;
    logic hi_arm;
    logic ack;
    logic [31:0] rdata;
    logic trap;
    logic hold;
    logic pri_en;
    logic low_power_rc_en;
  } state_s;

  state_s s_ff;
  state_s nxt_s;

  // PLL gain from the primary mode: 01 x4, 10 x8, 11 x16 when bit 2 set.
  function automatic logic [1:0] pll_gain(input logic [3:0] mode);
    pll_gain = mode[2] ? mode[1:0] : PLL_OFF;
  endfunction

  // Crystal sources need the start-up counter before release.
  function automatic logic is_crystal(input logic [1:0] grp, input logic [3:0] mode);
    is_crystal = (grp == GRP_SECONDARY) || (grp == GRP_PRIMARY && !mode[3]);
  endfunction

  logic sw_en;
  logic mon_en;
  logic powerup_timer_done;
  logic low_power_rc_tick;
  logic probe_edge;
  logic [1:0] probe_grp;
  logic src_ready;
  logic mon_active;
  logic fail;
  logic req;
  logic acc;
  logic [31:0] ctrl_word;

  always_comb begin
    sw_en = !s_ff.cfg_mon[1];  // see [R19]
    mon_en = (s_ff.cfg_mon == MON_CFG_BOTH_ON);  // see [R19]
    powerup_timer_done = s_ff.powerup_timer_s[1];
    low_power_rc_tick = s_ff.low_power_rc_s[1] && !s_ff.low_power_rc_s[2];
    probe_edge = s_ff.probe_s[1] ^ s_ff.probe_s[2];
    probe_grp = (s_ff.st == SW_IDLE) ? s_ff.cur_grp : s_ff.new_grp;
    // The secondary oscillator only clocks the system while enabled. see [R2]
    src_ready = !(probe_grp == GRP_SECONDARY && !s_ff.sosc)
      && (!is_crystal(probe_grp, s_ff.cfg_mode) || s_ff.sup_cnt == STARTUP_CYCLES)
      && (probe_grp != GRP_PRIMARY || pll_gain(s_ff.cfg_mode) == PLL_OFF
        || s_ff.lock_s[1]);
    mon_active = mon_en && !SLEEP_I && powerup_timer_done && s_ff.st == SW_IDLE
      && s_ff.cur_grp != GRP_FAST_RC;
    // Missing edges within the window, or a source still starting at timer expiry.
    fail = (mon_active && s_ff.mon_cnt == MON_LIMIT)  // see [R24]
      || (mon_en && s_ff.powerup_timer_s[1] && !s_ff.powerup_timer_seen && !src_ready
        && s_ff.cur_grp != GRP_FAST_RC);  // see [R13]
    req = AVS_READ_I || AVS_WRITE_I;
    acc = req && s_ff.ack;
    ctrl_word = '0;
    ctrl_word[BIT_SWITCH_ENABLE] = s_ff.switch_enable;
    ctrl_word[BIT_SEC_OSC_ENABLE] = s_ff.sosc;
    ctrl_word[BIT_CLOCK_FAIL] = s_ff.cf;
    ctrl_word[BIT_LOCK] = s_ff.lock_s[1];  // see [R4]
    ctrl_word[NEW_GROUP_LSB +: 2] = s_ff.new_grp;
    ctrl_word[CUR_GROUP_LSB +: 2] = s_ff.cur_grp;  // see [R16]
    ctrl_word[FINE_TUNE_LSB +: 4] = s_ff.tune;

    nxt_s = s_ff;
    nxt_s.powerup_timer_s = {s_ff.powerup_timer_s[0], POWERUP_TIMER_DONE_I};
    nxt_s.lock_s = {s_ff.lock_s[0], PLL_LOCK_I};
    nxt_s.low_power_rc_s = {s_ff.low_power_rc_s[1:0], LOW_POWER_RC_CLK_I};
    nxt_s.probe_s = {s_ff.probe_s[1:0], OSC_PROBE_I};
    nxt_s.powerup_timer_seen = powerup_timer_done;
    nxt_s.trap = 1'b0;

    // Start-up counter restarts in Sleep so that wake-up waits again. see [R22]
    if (SLEEP_I) begin
      nxt_s.sup_cnt = '0;
    end else if (probe_edge && s_ff.sup_cnt != STARTUP_CYCLES) begin
      nxt_s.sup_cnt = s_ff.sup_cnt + 11'h001;
    end

    // Edges of the source reset the window; ticks fill it. see [R24]
    if (probe_edge || !mon_active) begin
      nxt_s.mon_cnt = '0;
    end else if (low_power_rc_tick && s_ff.mon_cnt != MON_LIMIT) begin
      nxt_s.mon_cnt = s_ff.mon_cnt + MON_W'(1);
    end

    // Avalon answer: one wait cycle, then data and write take effect.
    nxt_s.ack = req && !s_ff.ack;
    if (req && !s_ff.ack) begin
      nxt_s.rdata = (AVS_READ_I && AVS_ADDRESS_I == ADDR_CTRL) ? ctrl_word : '0;
    end
    if (acc) begin
      // An unlock lasts for the single next access only.
      nxt_s.lo_arm = 1'b0;
      nxt_s.hi_arm = 1'b0;
      nxt_s.key_st = KEY_NONE;
      if (AVS_WRITE_I && AVS_ADDRESS_I == ADDR_KEY && AVS_BYTEENABLE_I[0]) begin
        unique case (AVS_WRITEDATA_I[7:0])
          KEY_LO_FIRST: nxt_s.key_st = KEY_LO_HALF;
          KEY_HI_FIRST: nxt_s.key_st = KEY_HI_HALF;
          KEY_LO_SECOND: nxt_s.lo_arm = (s_ff.key_st == KEY_LO_HALF);  // see [R23]
          KEY_HI_SECOND: nxt_s.hi_arm = (s_ff.key_st == KEY_HI_HALF);  // see [R23]
          default: nxt_s.key_st = KEY_NONE;
        endcase
      end
      if (AVS_WRITE_I && AVS_ADDRESS_I == ADDR_CTRL) begin
        if (AVS_BYTEENABLE_I[0] && s_ff.lo_arm) begin
          nxt_s.switch_enable = AVS_WRITEDATA_I[BIT_SWITCH_ENABLE] && sw_en;  // see [R18]
          nxt_s.sosc = AVS_WRITEDATA_I[BIT_SEC_OSC_ENABLE];  // see [R1]
          // The fail flag can only be cleared by software, never set.
          nxt_s.cf = s_ff.cf && AVS_WRITEDATA_I[BIT_CLOCK_FAIL];
        end
        if (AVS_BYTEENABLE_I[1] && s_ff.hi_arm) begin
          nxt_s.new_grp = AVS_WRITEDATA_I[NEW_GROUP_LSB +: 2];  // see [R16]
        end
        if (AVS_BYTEENABLE_I[2] && s_ff.hi_arm) begin
          nxt_s.tune = AVS_WRITEDATA_I[FINE_TUNE_LSB +: 4];  // see [R6]
        end
      end
    end

    // Group switching among the four groups only. see [R15]
    unique case (s_ff.st)
      SW_IDLE: begin
        if (s_ff.switch_enable && s_ff.new_grp != s_ff.cur_grp) begin
          nxt_s.st = SW_START;
          nxt_s.sup_cnt = '0;
        end else if (s_ff.switch_enable) begin
          nxt_s.switch_enable = 1'b0;
        end
      end
      SW_START: begin
        if (!s_ff.switch_enable) begin
          nxt_s.st = SW_IDLE;  // see [R18]
          nxt_s.sup_cnt = '0;
        end else if (src_ready) begin
          nxt_s.st = SW_SWAP;
        end
      end
      SW_SWAP: begin
        nxt_s.st = SW_IDLE;
        nxt_s.cur_grp = s_ff.new_grp;
        nxt_s.switch_enable = 1'b0;
      end
    endcase

    // Failure overrides any switch and any software write of switch enable or fail flag. see [R11]
    if (fail) begin
      nxt_s.cur_grp = GRP_FAST_RC;  // see [R12]
      nxt_s.cf = 1'b1;  // see [R12]
      nxt_s.switch_enable = 1'b0;  // see [R12]
      nxt_s.st = SW_IDLE;
      nxt_s.trap = 1'b1;  // see [R11]
    end

    // Without switching the straps select the source directly. see [R20]
    if (!sw_en) begin
      nxt_s.cur_grp = s_ff.cfg_start;
      nxt_s.switch_enable = 1'b0;
      nxt_s.st = SW_IDLE;
    end

    nxt_s.hold = (s_ff.st == SW_IDLE) && !src_ready;  // see [R22]
    // The primary oscillator is shut off once fast RC has taken over; the secondary enable is kept. see [R13]
    nxt_s.pri_en = (s_ff.cur_grp == GRP_PRIMARY)
      || (s_ff.st != SW_IDLE && s_ff.new_grp == GRP_PRIMARY);
    // Low-power RC keeps running across a failure for the watchdog. see [R14]
    nxt_s.low_power_rc_en = !powerup_timer_done  // see [R8]
      || (mon_en && !SLEEP_I)  // see [R10]
      || s_ff.cfg_wdt
      || (!mon_en && WATCHDOG_SOFT_ENABLE_I)
      || s_ff.cur_grp == GRP_LOW_POWER_RC;  // see [R9]

    if (!RESETN_I) begin
      nxt_s = '0;
      nxt_s.cfg_start = START_GROUP_CFG_I;
      nxt_s.cfg_mode = PRIMARY_MODE_CFG_I;
      nxt_s.cfg_mon = MONITOR_SELECT_CFG_I;
      nxt_s.cfg_wdt = WATCHDOG_CFG_ENABLE_I;
      nxt_s.cur_grp = START_GROUP_CFG_I;  // see [R17]
      nxt_s.new_grp = START_GROUP_CFG_I;  // see [R17]
      nxt_s.sosc = (START_GROUP_CFG_I == GRP_SECONDARY);
      nxt_s.tune = FINE_TUNE_RESET;
      nxt_s.st = SW_IDLE;
      nxt_s.key_st = KEY_NONE;
      nxt_s.hold = 1'b1;
      nxt_s.low_power_rc_en = 1'b1;  // see [R8]
    end
  end

  always_ff @(posedge REF_CLK_I) begin
    s_ff <= nxt_s;
  end

  assign AVS_WAITREQUEST_O = req && !s_ff.ack;
  assign AVS_READDATA_O = s_ff.rdata;
  assign CLK_SELECT_O = s_ff.cur_grp;  // see [R5]
  assign PRIMARY_MODE_O = s_ff.cfg_mode;  // see [R15]
  assign PLL_GAIN_O = pll_gain(s_ff.cfg_mode);  // see [R3]
  assign PRIMARY_OSC_EN_O = s_ff.pri_en;
  assign SECONDARY_OSC_EN_O = s_ff.sosc;  // see [R1]
  // This enable is the clock of timer, watchdog and this monitor. see [R7]
  assign LOW_POWER_RC_EN_O = s_ff.low_power_rc_en;
  assign FINE_TUNE_O = s_ff.tune;  // see [R6]
  assign OSC_PROBE_SEL_O = probe_grp;
  assign CLOCK_HOLD_O = s_ff.hold;
  assign CLOCK_FAIL_TRAP_O = s_ff.trap;

  sequence s_answer;
    !AVS_WAITREQUEST_O;
  endsequence

  property p_fail_switch;
    @(posedge REF_CLK_I) disable iff (!RESETN_I)
    (fail && sw_en) |=> (s_ff.cur_grp == GRP_FAST_RC && s_ff.cf && !s_ff.switch_enable);
  endproperty
  a_fail_switch: assert property (p_fail_switch) else $error("failure did not switch"); // [R12]

  property p_trap_flag;
    @(posedge REF_CLK_I) disable iff (!RESETN_I)
    fail |=> (CLOCK_FAIL_TRAP_O && s_ff.cf) ##1 (!CLOCK_FAIL_TRAP_O || $past(fail));
  endproperty
  a_trap_flag: assert property (p_trap_flag) else $error("trap pulse wrong"); // [R11]

  property p_disabled_follow;
    @(posedge REF_CLK_I) disable iff (!RESETN_I)
    (!sw_en && $stable(s_ff.cfg_start)) |=> s_ff.cur_grp == s_ff.cfg_start;
  endproperty
  a_disabled_follow: assert property (p_disabled_follow) else $error("group not strap"); // [R20]

  property p_secondary_hold;
    @(posedge REF_CLK_I) disable iff (!RESETN_I)
    (s_ff.st == SW_IDLE && s_ff.cur_grp == GRP_SECONDARY && !s_ff.sosc) |=> CLOCK_HOLD_O;
  endproperty
  a_secondary_hold: assert property (p_secondary_hold) else $error("secondary not held"); // [R2]

  property p_low_power_rc_por;
    @(posedge REF_CLK_I) disable iff (!RESETN_I)
    !powerup_timer_done |=> LOW_POWER_RC_EN_O;
  endproperty
  a_low_power_rc_por: assert property (p_low_power_rc_por) else $error("low-power RC off early"); // [R8]

  property p_low_power_rc_off;
    @(posedge REF_CLK_I) disable iff (!RESETN_I)
    (powerup_timer_done && !mon_en && !s_ff.cfg_wdt && !WATCHDOG_SOFT_ENABLE_I
      && s_ff.cur_grp != GRP_LOW_POWER_RC) |=> !LOW_POWER_RC_EN_O;
  endproperty
  a_low_power_rc_off: assert property (p_low_power_rc_off) else $error("low-power RC left on"); // [R9]

  property p_low_power_rc_monitor;
    @(posedge REF_CLK_I) disable iff (!RESETN_I)
    (mon_en && !SLEEP_I) [*2] |-> LOW_POWER_RC_EN_O;
  endproperty
  a_low_power_rc_monitor: assert property (p_low_power_rc_monitor) else $error("monitor clock off"); // [R10]

  property p_abort;
    @(posedge REF_CLK_I) disable iff (!RESETN_I)
    (s_ff.st == SW_START && !s_ff.switch_enable && sw_en) |=> s_ff.st == SW_IDLE;
  endproperty
  a_abort: assert property (p_abort) else $error("switch not aborted"); // [R18]

  property p_lock_read;
    @(posedge REF_CLK_I) disable iff (!RESETN_I)
    (AVS_READ_I && !AVS_WAITREQUEST_O && AVS_ADDRESS_I == ADDR_CTRL)
      |-> AVS_READDATA_O[BIT_LOCK] == $past(s_ff.lock_s[1]);
  endproperty
  a_lock_read: assert property (p_lock_read) else $error("lock bit mismatch"); // [R4]

  property p_startup_hold;
    @(posedge REF_CLK_I) disable iff (!RESETN_I)
    (s_ff.st == SW_IDLE && is_crystal(s_ff.cur_grp, s_ff.cfg_mode)
      && s_ff.sup_cnt != STARTUP_CYCLES) |=> CLOCK_HOLD_O;
  endproperty
  a_startup_hold: assert property (p_startup_hold) else $error("crystal released early"); // [R22]

  property p_bus_answer;
    @(posedge REF_CLK_I) disable iff (!RESETN_I)
    (req && AVS_WAITREQUEST_O) |=> s_answer;
  endproperty
  a_bus_answer: assert property (p_bus_answer) else $error("bus answer late");

endmodule

// ### src/clk_sw_pkg.sv
// Shared constants and types for the clock source switch and fail monitor.
package clk_sw_pkg;

  // Register byte addresses on the Avalon-MM slave.
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_KEY = 4'h4;

  // Clock source groups.
  localparam logic [1:0] GRP_SECONDARY = 2'h0;
  localparam logic [1:0] GRP_FAST_RC = 2'h1;
  localparam logic [1:0] GRP_LOW_POWER_RC = 2'h2;
  localparam logic [1:0] GRP_PRIMARY = 2'h3;

  // Field positions in osc_control_reg.
  localparam int BIT_SWITCH_ENABLE = 0;
  localparam int BIT_SEC_OSC_ENABLE = 1;
  localparam int BIT_CLOCK_FAIL = 3;
  localparam int BIT_LOCK = 5;
  localparam int NEW_GROUP_LSB = 8;
  localparam int CUR_GROUP_LSB = 12;
  localparam int FINE_TUNE_LSB = 16;

  // Reset values of software fields.
  localparam logic [3:0] FINE_TUNE_RESET = 4'h0;

  // Unlock keys written to the key register, low byte then high byte.
  localparam logic [7:0] KEY_LO_FIRST = 8'h46;
  localparam logic [7:0] KEY_LO_SECOND = 8'h57;
  localparam logic [7:0] KEY_HI_FIRST = 8'h78;
  localparam logic [7:0] KEY_HI_SECOND = 8'h9a;

  // Monitor select: bit 1 set disables switching and monitoring.
  localparam logic [1:0] MON_CFG_BOTH_ON = 2'h0;

  // PLL gain codes driven to the PLL.
  localparam logic [1:0] PLL_OFF = 2'h0;

  // Start-up counter: source edges, rising and falling, before a crystal clock is released.
  localparam logic [10:0] STARTUP_CYCLES = 11'h400;

  // Default fail window in low-power RC ticks.
  localparam int FAIL_WINDOW_DEFAULT = 8;

  typedef enum logic [1:0] {
    SW_IDLE = 2'b00,
    SW_START = 2'b01,
    SW_SWAP = 2'b11
  } switch_state_e;

  typedef enum logic [1:0] {
    KEY_NONE = 2'b00,
    KEY_LO_HALF = 2'b01,
    KEY_HI_HALF = 2'b11
  } key_state_e;

endpackage

// ### test/osc_source_model.sv
// Behavioural clock sources: low-power RC, probed oscillators and PLL lock.
`timescale 1ns/100ps
module osc_source_model (
  // Controls from the block
  input wire logic clk_i,
  input wire logic low_power_rc_en_i,
  input wire logic pri_en_i,
  input wire logic sec_en_i,
  input wire logic [1:0] probe_sel_i,
  // Bench controls
  input wire logic [3:0] alive_i,
  input wire logic lock_i,
  // Source outputs
  output logic low_power_rc_clk_o,
  output logic probe_o,
  output logic lock_o
);
  logic [1:0] div_ff = 2'h0;
  logic tog_ff = 1'b0;
  logic run;
  // A dead or disabled source stands still; the monitor has to notice that.
  assign run = alive_i[probe_sel_i] && (probe_sel_i == 2'h1
    || (probe_sel_i == 2'h0 && sec_en_i) || (probe_sel_i == 2'h2 && low_power_rc_en_i)
    || (probe_sel_i == 2'h3 && pri_en_i));
  always @(posedge clk_i) begin
    if (low_power_rc_en_i) begin
      div_ff <= div_ff + 2'h1;
    end
    // Every running source toggles each clock, well above the monitor window.
    if (run) begin
      tog_ff <= ~tog_ff;
    end
  end
  assign probe_o = tog_ff;
  assign low_power_rc_clk_o = div_ff[1];
  assign lock_o = lock_i;
endmodule

// ### test/tb_clock_source_switch.sv
// Self-checking bench for the clock source switch and fail monitor.
`timescale 1ns/100ps
module tb_clock_source_switch;
  import clk_sw_pkg::*;
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic [3:0] addr = 4'h0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [3:0] be = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic [1:0] grp_cfg = GRP_FAST_RC;
  logic [3:0] mode_cfg = 4'h2;
  logic [1:0] mon_cfg = MON_CFG_BOTH_ON;
  logic sleep = 1'b0;
  logic wdt_soft = 1'b0;
  logic timer_done = 1'b0;
  logic lock_req = 1'b0;
  logic [3:0] alive = 4'hf;
  logic [31:0] rdata;
  logic waitreq, pll_lock, low_power_rc_clk, probe, pri_en, sec_en, low_power_rc_en, hold, trap;
  logic [1:0] clk_sel, pll_gain, probe_sel;
  logic [3:0] mode_o, fine_o;
  int failures = 0;
  int tests_run = 0;
  always #2 ref_clk = ~ref_clk;
  clock_source_switch #(.FAIL_WINDOW_TICKS(2)) u_dut (
    .REF_CLK_I(ref_clk), .RESETN_I(resetn), .AVS_ADDRESS_I(addr), .AVS_READ_I(rd),
    .AVS_WRITE_I(wr), .AVS_BYTEENABLE_I(be), .AVS_WRITEDATA_I(wdata),
    .AVS_READDATA_O(rdata), .AVS_WAITREQUEST_O(waitreq), .START_GROUP_CFG_I(grp_cfg),
    .PRIMARY_MODE_CFG_I(mode_cfg), .MONITOR_SELECT_CFG_I(mon_cfg),
    .WATCHDOG_CFG_ENABLE_I(1'b0), .SLEEP_I(sleep), .WATCHDOG_SOFT_ENABLE_I(wdt_soft),
    .POWERUP_TIMER_DONE_I(timer_done), .PLL_LOCK_I(pll_lock),
    .LOW_POWER_RC_CLK_I(low_power_rc_clk), .OSC_PROBE_I(probe), .CLK_SELECT_O(clk_sel),
    .PRIMARY_MODE_O(mode_o), .PLL_GAIN_O(pll_gain), .PRIMARY_OSC_EN_O(pri_en),
    .SECONDARY_OSC_EN_O(sec_en), .LOW_POWER_RC_EN_O(low_power_rc_en), .FINE_TUNE_O(fine_o),
    .OSC_PROBE_SEL_O(probe_sel), .CLOCK_HOLD_O(hold), .CLOCK_FAIL_TRAP_O(trap));
  osc_source_model u_src (
    .clk_i(ref_clk), .low_power_rc_en_i(low_power_rc_en), .pri_en_i(pri_en), .sec_en_i(sec_en),
    .probe_sel_i(probe_sel), .alive_i(alive), .lock_i(lock_req),
    .low_power_rc_clk_o(low_power_rc_clk), .probe_o(probe), .lock_o(pll_lock));

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic results();
    $display("Checks %0d, mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // One Avalon-MM access; the request stands until waitrequest is sampled low.
  task automatic bus(input logic w, input logic [3:0] a, input logic [3:0] b,
                     input logic [31:0] d, output logic [31:0] q);
    int n;
    @(posedge ref_clk);
    addr <= a;
    be <= b;
    wdata <= d;
    wr <= w;
    rd <= ~w;
    for (n = 0; n < 20; n++) begin
      @(posedge ref_clk);
      if (waitreq === 1'b0) break;
    end
    q = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
    check("waitrequest", 32'(n < 20), 32'h1);
    if (n == 20) results();
  endtask
  task automatic ctl_wr(input logic hi, input logic [3:0] b, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, ADDR_KEY, 4'h1, {24'h0, hi ? KEY_HI_FIRST : KEY_LO_FIRST}, q);
    bus(1'b1, ADDR_KEY, 4'h1, {24'h0, hi ? KEY_HI_SECOND : KEY_LO_SECOND}, q);
    bus(1'b1, ADDR_CTRL, b, d, q);
  endtask
  task automatic ctl_rd(output logic [31:0] q);
    bus(1'b0, ADDR_CTRL, 4'hf, 32'h0, q);
  endtask
  task automatic wait_bit(input bit lp, input logic v, input int lim);
    int n;
    for (n = 0; n < lim; n++) begin
      @(posedge ref_clk);
      if ((lp ? low_power_rc_en : trap) === v) break;
    end
    check(lp ? "low_power_rc_en" : "trap", 32'(n < lim), 32'h1);
    if (n == lim) results();
  endtask
  task automatic wait_grp(input logic [1:0] g, input int lim);
    int n;
    for (n = 0; n < lim && clk_sel !== g; n++) @(posedge ref_clk);
    check("clk_select", 32'(clk_sel), 32'(g));
    if (n == lim) results();
  endtask
  task automatic do_reset(input logic [1:0] g, input logic [3:0] m, input logic [1:0] mc);
    @(posedge ref_clk);
    resetn <= 1'b0;
    grp_cfg <= g;
    mode_cfg <= m;
    mon_cfg <= mc;
    timer_done <= 1'b0;
    wdt_soft <= 1'b0;
    repeat (3) @(posedge ref_clk);
    resetn <= 1'b1;
  endtask

  task automatic s_gain();
    logic [1:0] g[3];
    // External clock with the PLL: the system clock waits for lock only.
    for (int i = 0; i < 3; i++) begin
      do_reset(GRP_PRIMARY, 4'hd + 4'(i), MON_CFG_BOTH_ON);
      repeat (2) @(posedge ref_clk);
      g[i] = pll_gain;
      check("pll_gain", 32'(g[i]), 32'(i + 1));
      check("pll_wait_lock", 32'(hold), 32'h1);
    end
    check("pll_gain_apart", 32'(g[0] != g[1] && g[1] != g[2] && g[0] != g[2]), 32'h1);
    lock_req <= 1'b1;
    repeat (8) @(posedge ref_clk);
    check("pll_lock_release", 32'(hold), 32'h0);
    lock_req <= 1'b0;
  endtask
  task automatic s_reset();
    logic [31:0] q;
    @(posedge ref_clk);
    check("low_power_rc_en_boot", 32'(low_power_rc_en), 32'h1);
    ctl_rd(q);
    check("cur_group", 32'(q[13:12]), 32'(GRP_FAST_RC));
    check("hold_fast_rc", 32'(hold), 32'h0);
    check("new_group", 32'(q[9:8]), 32'(GRP_FAST_RC));
    check("ctl_low", 32'({q[19:16], q[3], q[0]}), 32'h0);
    bus(1'b0, 4'h8, 4'hf, 32'h0, q);
    check("unmapped", q, 32'h0);
    timer_done <= 1'b1;
  endtask
  task automatic s_tune();
    logic [31:0] q;
    bus(1'b1, ADDR_CTRL, 4'h4, 32'h0007_0000, q);
    check("tune_locked", 32'(fine_o), 32'(FINE_TUNE_RESET));
    ctl_wr(1'b1, 4'h4, 32'h0008_0000);
    ctl_rd(q);
    check("tune_reg", 32'(q[19:16]), 32'h8);
    check("tune_out", 32'(fine_o), 32'h8);
    lock_req <= 1'b1;
    repeat (6) @(posedge ref_clk);
    ctl_rd(q);
    check("lock_set", 32'(q[BIT_LOCK]), 32'h1);
    lock_req <= 1'b0;
    repeat (6) @(posedge ref_clk);
    ctl_rd(q);
    check("lock_lost", 32'(q[BIT_LOCK]), 32'h0);
  endtask
  task automatic s_switch();
    logic [31:0] q;
    ctl_wr(1'b1, 4'h2, 32'h0000_0300);
    ctl_rd(q);
    check("cur_ro", 32'(q[13:12]), 32'(GRP_FAST_RC));
    ctl_wr(1'b0, 4'h1, 32'h1);
    ctl_rd(q);
    check("sw_en_set", 32'(q[0]), 32'h1);
    check("probe_target", 32'(probe_sel), 32'(GRP_PRIMARY));
    wait_grp(GRP_PRIMARY, 3000);
    ctl_rd(q);
    check("sw_done", 32'({q[13:12], q[0]}), 32'h6);
    check("pri_mode", 32'(mode_o), 32'h2);
  endtask
  task automatic s_abort();
    logic [31:0] q;
    ctl_wr(1'b1, 4'h2, 32'h0);
    ctl_wr(1'b0, 4'h1, 32'h1);
    repeat (20) @(posedge ref_clk);
    check("stalled", 32'(clk_sel), 32'(GRP_PRIMARY));
    ctl_wr(1'b0, 4'h1, 32'h0);
    ctl_rd(q);
    check("aborted", 32'({q[13:12], q[0]}), 32'h6);
    ctl_wr(1'b0, 4'h1, 32'h3);
    // The enable lands at the answering edge; look once it is registered.
    @(posedge ref_clk);
    check("sec_en", 32'(sec_en), 32'h1);
    // The secondary crystal also waits out the start-up count.
    wait_grp(GRP_SECONDARY, 3000);
    sleep <= 1'b1;
    repeat (4) @(posedge ref_clk);
    check("sec_sleep", 32'(sec_en), 32'h1);
    sleep <= 1'b0;
  endtask
  task automatic s_fail();
    logic [31:0] q;
    repeat (3000) @(posedge ref_clk);
    alive <= 4'he;
    wait_bit(1'b0, 1'b1, 200);
    @(posedge ref_clk);
    check("trap_pulse", 32'(trap), 32'h0);
    check("fail_grp", 32'(clk_sel), 32'(GRP_FAST_RC));
    check("low_power_rc_kept", 32'(low_power_rc_en), 32'h1);
    ctl_rd(q);
    check("fail_reg", 32'({q[13:12], q[3], q[0]}), 32'h6);
    ctl_wr(1'b0, 4'h1, 32'h2);
    ctl_rd(q);
    check("cf_clear", 32'(q[BIT_CLOCK_FAIL]), 32'h0);
    alive <= 4'hf;
  endtask
  task automatic s_boot_fail();
    do_reset(GRP_PRIMARY, 4'h2, MON_CFG_BOTH_ON);
    alive <= 4'h7;
    repeat (5) @(posedge ref_clk);
    check("boot_hold", 32'(hold), 32'h1);
    timer_done <= 1'b1;
    wait_bit(1'b0, 1'b1, 50);
    wait_grp(GRP_FAST_RC, 5);
    repeat (2) @(posedge ref_clk);
    check("pri_off", 32'(pri_en), 32'h0);
    alive <= 4'hf;
  endtask
  task automatic s_fixed();
    logic [31:0] q;
    do_reset(GRP_PRIMARY, 4'h2, 2'h2);
    @(posedge ref_clk);
    check("low_power_rc_boot", 32'(low_power_rc_en), 32'h1);
    timer_done <= 1'b1;
    wait_bit(1'b1, 1'b0, 50);
    ctl_wr(1'b1, 4'h2, 32'h0000_0100);
    ctl_wr(1'b0, 4'h1, 32'h1);
    repeat (20) @(posedge ref_clk);
    check("no_switch", 32'(clk_sel), 32'(GRP_PRIMARY));
    ctl_rd(q);
    check("cur_reflect", 32'(q[13:12]), 32'(GRP_PRIMARY));
    wdt_soft <= 1'b1;
    wait_bit(1'b1, 1'b1, 50);
  endtask

  initial begin
    s_gain();
    do_reset(GRP_FAST_RC, 4'h2, MON_CFG_BOTH_ON);
    s_reset();
    s_tune();
    s_switch();
    s_abort();
    s_fail();
    s_boot_fail();
    s_fixed();
    results();
  end
endmodule
